// ### common/dlm_pkg.sv
// package: constants and carrier types for the dual-port lane mapper
package dlm_pkg;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] DLM_CTRL_OFS = 8'h00;
	localparam logic [7:0] DLM_STRAP_OFS = 8'h04;
	localparam logic [7:0] DLM_STAT_OFS = 8'h08;

	// control register fields
	localparam int DLM_CTRL_FSYNC_BIT = 0;
	localparam int DLM_CTRL_TSYNC_BIT = 1;
	localparam logic [1:0] DLM_CTRL_RST = 2'h0;

	// status register fields
	localparam int DLM_STAT_OVR_BIT = 0;
	localparam int DLM_STAT_LVL_LSB = 1;

	// strap register fields
	localparam int DLM_STRAP_ORDA_LSB = 0;
	localparam int DLM_STRAP_FLIPA_BIT = 2;
	localparam int DLM_STRAP_ORDB_LSB = 3;
	localparam int DLM_STRAP_FLIPB_BIT = 5;
	localparam int DLM_STRAP_PORD_BIT = 6;
	localparam int DLM_STRAP_CMD_BIT = 7;
	localparam int DLM_STRAP_HOST_LSB = 8;
	localparam int DLM_STRAP_MODE_LSB = 10;

	// ****************************************
	// lane-order and host-link codes
	// ****************************************
	localparam logic [1:0] DLM_ORD_3210 = 2'h0;
	localparam logic [1:0] DLM_ORD_0123 = 2'h1;
	localparam logic [1:0] DLM_ORD_2103 = 2'h2;
	localparam logic [1:0] DLM_ORD_3012 = 2'h3;
	localparam logic [1:0] DLM_HOST_I2C0 = 2'h0;
	localparam logic [1:0] DLM_HOST_SPI = 2'h1;
	localparam logic [1:0] DLM_HOST_I2C1 = 2'h2;

	// cycles after reset release before straps are latched
	localparam logic [1:0] DLM_STRAP_SETTLE = 2'h3;

	typedef enum logic [1:0] {
		DLM_LINK_I2C,
		DLM_LINK_SPI,
		DLM_LINK_NONE
	} dlm_link_mode_t;

	// one port's pins as single-ended samples
	typedef struct packed {
		logic clk_pos;
		logic [3:0] lane_pos;
		logic [3:0] lane_neg;
	} dlm_port_pins_t;

	// latched strap set
	typedef struct packed {
		logic [1:0] host_link;
		logic cmd_port;
		logic port_order;
		logic flip_b;
		logic [1:0] order_b;
		logic flip_a;
		logic [1:0] order_a;
	} dlm_straps_t;

	// one paired word: first and second part of the line
	typedef struct packed {
		logic [3:0] first;
		logic [3:0] second;
	} dlm_word_t;

endpackage : dlm_pkg

// ### verilog/dlm_lane_mapper.sv
// dual-port lane mapper: strap decode, lane/polarity mapping, apb regs
// Operation
// RL1: order code places logical lanes on pins
// RL2: polarity flip swaps legs on D0,D2,D3
// RL3: ports A and B configured independently
// RL4: port-order strap picks first line part
// RL5: command-port strap picks data order, commands
// RL6: host strap selects I2C or SPI sideband
// RL7: host strap bit0 pulled low when open
// RL8: frame sync output low unless enabled
// RL9: touch sync output low unless enabled
// RL10: each port: clock lane, four bidirectional lanes; lanes receive only here, oe held 0
// RL11: straps static, captured at reset release
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module dlm_lane_mapper (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire dlm_pkg::dlm_port_pins_t port_a_pins,
	input wire dlm_pkg::dlm_port_pins_t port_b_pins,
	output logic [3:0] port_a_lane_oe,
	output logic [3:0] port_b_lane_oe,
	input wire logic [1:0] lane_order_code_a,
	input wire logic [1:0] lane_order_code_b,
	input wire logic lane_polarity_flip_a,
	input wire logic lane_polarity_flip_b,
	input wire logic port_order_select,
	input wire logic cmd_port_select,
	input wire logic [1:0] host_link_select,
	output dlm_pkg::dlm_link_mode_t host_link_mode,
	output logic [3:0] cmd_lanes,
	output logic cmd_lanes_valid,
	output dlm_pkg::dlm_word_t word_data,
	output logic word_valid,
	input wire logic word_ready,
	input wire logic frame_sync_src,
	input wire logic touch_sync_src,
	output logic frame_sync_out,
	output logic touch_sync_out
);
	import dlm_pkg::*;

	// ****************************************
	// functions
	// ****************************************

	// polarity: swapped pairs read their negative leg
	function automatic logic [3:0] fix_polarity(
		input logic flip,
		input logic [3:0] pos,
		input logic [3:0] neg
	);
		return flip ? {neg[3:2], pos[1], neg[0]} : pos; // [RL2]
	endfunction : fix_polarity

	// pin bits p[0..3] to logical lanes
	function automatic logic [3:0] map_lanes(
		input logic [1:0] code,
		input logic [3:0] p
	);
		case (code)
			DLM_ORD_3210: return {p[0], p[1], p[2], p[3]}; // [RL1]
			DLM_ORD_0123: return p; // [RL1]
			DLM_ORD_2103: return {p[3], p[0], p[1], p[2]}; // [RL1]
			DLM_ORD_3012: return {p[0], p[3], p[2], p[1]}; // [RL1]
			default: return p;
		endcase
	endfunction : map_lanes

	// ****************************************
	// input synchronisers
	// ****************************************
	dlm_port_pins_t pa_s1_q, pa_s2_q, pb_s1_q, pb_s2_q;
	dlm_straps_t st_s1_q, st_s2_q;
	dlm_straps_t straps_q;
	logic pa_clk_d1_q, pb_clk_d1_q;
	// two flops on every lane, clock and strap pin before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pa_s1_q <= '0;
			pa_s2_q <= '0;
			pb_s1_q <= '0;
			pb_s2_q <= '0;
			st_s1_q <= '0;
			st_s2_q <= '0;
		end else begin
			pa_s1_q <= port_a_pins;
			pa_s2_q <= pa_s1_q;
			pb_s1_q <= port_b_pins;
			pb_s2_q <= pb_s1_q;
			st_s1_q <= {host_link_select, cmd_port_select, port_order_select,
				lane_polarity_flip_b, lane_order_code_b,
				lane_polarity_flip_a, lane_order_code_a};
			st_s2_q <= st_s1_q;
		end
	end

	// ****************************************
	// strap capture
	// ****************************************
	logic [1:0] settle_q;
	logic straps_ok_q;
	// latch straps once after release, then hold them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_q <= '0;
			straps_ok_q <= 1'b0;
			straps_q <= '0;
		end else if (!straps_ok_q) begin
			if (settle_q == DLM_STRAP_SETTLE) begin
				straps_q <= st_s2_q; // [RL11]
				straps_ok_q <= 1'b1; // [RL11]
			end else begin
				settle_q <= settle_q + 2'h1;
			end
		end
	end
	// host sideband decode; open bit0 reads 0 via pad pull-down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_link_mode <= DLM_LINK_NONE;
		end else if (!straps_ok_q) begin
			host_link_mode <= DLM_LINK_NONE; // no mode before strap latch
		end else begin
			case (straps_q.host_link) // [RL7]
				DLM_HOST_I2C0: host_link_mode <= DLM_LINK_I2C; // [RL6]
				DLM_HOST_I2C1: host_link_mode <= DLM_LINK_I2C; // [RL6]
				DLM_HOST_SPI: host_link_mode <= DLM_LINK_SPI; // [RL6]
				default: host_link_mode <= DLM_LINK_NONE;
			endcase
		end
	end

	// ****************************************
	// lane capture on link clock edges
	// ****************************************
	logic a_edge, b_edge;
	logic [3:0] a_lanes, b_lanes;
	logic [3:0] a_hold_q, b_hold_q;
	logic a_have_q, b_have_q;
	logic pair_go;
	logic second_is_a;
	dlm_word_t pair_word;
	assign a_edge = pa_s2_q.clk_pos & ~pa_clk_d1_q;
	assign b_edge = pb_s2_q.clk_pos & ~pb_clk_d1_q;
	// each port uses its own strap set
	assign a_lanes = map_lanes(straps_q.order_a, fix_polarity(straps_q.flip_a,
		pa_s2_q.lane_pos, pa_s2_q.lane_neg)); // [RL3]
	assign b_lanes = map_lanes(straps_q.order_b, fix_polarity(straps_q.flip_b,
		pb_s2_q.lane_pos, pb_s2_q.lane_neg)); // [RL3]
	// port-order and command-port straps together choose line order
	assign second_is_a = straps_q.cmd_port ^ straps_q.port_order; // [RL4] [RL5]
	assign pair_word = second_is_a ? {b_hold_q, a_hold_q}
		: {a_hold_q, b_hold_q};
	assign pair_go = a_have_q & b_have_q;
	// hold each port's newest beat until its partner arrives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pa_clk_d1_q <= 1'b0;
			pb_clk_d1_q <= 1'b0;
			a_hold_q <= '0;
			b_hold_q <= '0;
			a_have_q <= 1'b0;
			b_have_q <= 1'b0;
		end else begin
			pa_clk_d1_q <= pa_s2_q.clk_pos;
			pb_clk_d1_q <= pb_s2_q.clk_pos;
			if (a_edge && straps_ok_q) begin
				a_hold_q <= a_lanes;
			end
			if (b_edge && straps_ok_q) begin
				b_hold_q <= b_lanes;
			end
			a_have_q <= (a_edge & straps_ok_q) | (a_have_q & ~pair_go);
			b_have_q <= (b_edge & straps_ok_q) | (b_have_q & ~pair_go);
		end
	end

	// command lanes come only from the command port
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_lanes <= '0;
			cmd_lanes_valid <= 1'b0;
		end else begin
			cmd_lanes_valid <= straps_ok_q &
				(straps_q.cmd_port ? b_edge : a_edge); // [RL5]
			if (straps_ok_q && straps_q.cmd_port && b_edge) begin
				cmd_lanes <= b_lanes; // [RL5]
			end else if (straps_ok_q && !straps_q.cmd_port && a_edge) begin
				cmd_lanes <= a_lanes; // [RL5]
			end
		end
	end

	// data lanes are bidirectional, receive only here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_a_lane_oe <= '0; // [RL10]
			port_b_lane_oe <= '0; // [RL10]
		end else begin
			port_a_lane_oe <= '0;
			port_b_lane_oe <= '0;
		end
	end

	// ****************************************
	// two-entry output buffer
	// ****************************************
	dlm_word_t skid_q;
	logic skid_v_q;
	logic buf_in_ready;
	logic push, pop;
	logic overrun_q;
	assign buf_in_ready = ~skid_v_q;
	assign push = pair_go & buf_in_ready;
	assign pop = word_valid & word_ready;
	// output stage plus skid entry; skid drains first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			word_data <= '0;
			word_valid <= 1'b0;
			skid_q <= '0;
			skid_v_q <= 1'b0;
		end else begin
			if (pop && skid_v_q) begin
				word_data <= skid_q;
				skid_v_q <= push;
				skid_q <= pair_word;
			end else if (pop) begin
				word_valid <= push;
				word_data <= pair_word;
			end else if (push && !word_valid) begin
				word_valid <= 1'b1;
				word_data <= pair_word;
			end else if (push) begin
				skid_v_q <= 1'b1;
				skid_q <= pair_word;
			end
		end
	end

	// ****************************************
	// sync outputs
	// ****************************************
	logic [1:0] ctrl_q;
	// outputs stay low while not enabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_sync_out <= 1'b0;
			touch_sync_out <= 1'b0;
		end else begin
			frame_sync_out <= ctrl_q[DLM_CTRL_FSYNC_BIT] & frame_sync_src; // [RL8]
			touch_sync_out <= ctrl_q[DLM_CTRL_TSYNC_BIT] & touch_sync_src; // [RL9]
		end
	end

	// ****************************************
	// apb slave
	// ****************************************
	logic acc;
	logic wr_go;
	logic hit;
	logic [31:0] rd_val;
	assign acc = psel & penable & ~pready;
	// writes land on the completing edge, with pready high
	assign wr_go = psel & penable & pready & pwrite;
	assign hit = (paddr == DLM_CTRL_OFS) | (paddr == DLM_STRAP_OFS) |
		(paddr == DLM_STAT_OFS);
	// read mux
	always_comb begin
		rd_val = '0;
		case (paddr)
			DLM_CTRL_OFS: rd_val[1:0] = ctrl_q;
			DLM_STRAP_OFS: begin
				rd_val[DLM_STRAP_MODE_LSB +: 2] = host_link_mode;
				rd_val[DLM_STRAP_HOST_LSB +: 2] = straps_q.host_link;
				rd_val[DLM_STRAP_CMD_BIT] = straps_q.cmd_port;
				rd_val[DLM_STRAP_PORD_BIT] = straps_q.port_order;
				rd_val[DLM_STRAP_FLIPB_BIT] = straps_q.flip_b;
				rd_val[DLM_STRAP_ORDB_LSB +: 2] = straps_q.order_b;
				rd_val[DLM_STRAP_FLIPA_BIT] = straps_q.flip_a;
				rd_val[DLM_STRAP_ORDA_LSB +: 2] = straps_q.order_a;
			end
			DLM_STAT_OFS: begin
				rd_val[DLM_STAT_OVR_BIT] = overrun_q;
				rd_val[DLM_STAT_LVL_LSB +: 2] = {1'b0, word_valid} +
					{1'b0, skid_v_q};
			end
			default: rd_val = '0;
		endcase
	end

	// one wait state: answer in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= acc;
			pslverr <= acc & ~hit;
			if (acc && !pwrite) begin
				prdata <= rd_val;
			end
		end
	end

	// control register steers the sync outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= DLM_CTRL_RST;
		end else if (wr_go && paddr == DLM_CTRL_OFS) begin
			ctrl_q <= pwdata[1:0]; // [RL8] [RL9]
		end
	end

	// sticky overrun: pair lost to a full buffer; set beats clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overrun_q <= 1'b0;
		end else if (pair_go && !buf_in_ready) begin
			overrun_q <= 1'b1;
		end else if (wr_go && paddr == DLM_STAT_OFS &&
			pwdata[DLM_STAT_OVR_BIT]) begin
			overrun_q <= 1'b0;
		end
	end

endmodule : dlm_lane_mapper
`default_nettype wire

// ### verif/dlm_host_model.sv
// model: dual-port host driving the lane pins
`timescale 1ns/10ps
`default_nettype none
module dlm_host_model (
	input wire logic pclk,
	output var dlm_pkg::dlm_port_pins_t port_a_pins,
	output var dlm_pkg::dlm_port_pins_t port_b_pins
);
	import dlm_pkg::*;
	// legs of one port, swapped board wiring leaves D1 alone
	function automatic dlm_port_pins_t drv(logic [3:0] b, logic f);
		return '{1'b0, b ^ {f, f, 1'b0, f}, ~b ^ {f, f, 1'b0, f}};
	endfunction : drv
	// clock still and legs low before the first frame
	initial begin
		port_a_pins = '0;
		port_b_pins = '0;
	end
	// one beat: data 3 cycles, clock high 4, legs invert (160 ns period)
	task automatic beat(input logic [3:0] a, input logic [3:0] b,
		input logic fa, input logic fb);
		@(posedge pclk);
		port_a_pins <= drv(a, fa);
		port_b_pins <= drv(b, fb);
		repeat (3) @(posedge pclk);
		port_a_pins.clk_pos <= 1'b1;
		port_b_pins.clk_pos <= 1'b1;
		repeat (4) @(posedge pclk);
		port_a_pins <= drv(~a, fa);
		port_b_pins <= drv(~b, fb);
	endtask : beat
endmodule : dlm_host_model
`default_nettype wire

// ### verif/dlm_lane_mapper_sva.sv
// checker: port properties of the lane mapper
`timescale 1ns/10ps
`default_nettype none
module dlm_lane_mapper_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] port_a_lane_oe,
	input wire logic [3:0] port_b_lane_oe,
	input wire logic [1:0] host_link_select,
	input wire dlm_pkg::dlm_link_mode_t host_link_mode,
	input wire dlm_pkg::dlm_word_t word_data,
	input wire logic word_valid,
	input wire logic word_ready,
	input wire logic cmd_lanes_valid,
	input wire logic frame_sync_src,
	input wire logic touch_sync_src,
	input wire logic frame_sync_out,
	input wire logic touch_sync_out
);
	import dlm_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// lanes are receive only
	a_oe_off: assert property (port_a_lane_oe == 4'h0 &&
		port_b_lane_oe == 4'h0) else $error("lane oe set");
	// sync outputs gated by their source
	a_fsync_gate: assert property (frame_sync_out |->
		$past(frame_sync_src)) else $error("fsync no source");
	a_tsync_gate: assert property ($rose(touch_sync_out) |->
		$past(touch_sync_src)) else $error("tsync no source");
	// decoded link mode matches the strap and holds once decoded
	a_spi_code: assert property (host_link_mode == DLM_LINK_SPI |->
		host_link_select == 2'h1) else $error("spi bad code");
	a_i2c_code: assert property (host_link_mode == DLM_LINK_I2C |->
		!host_link_select[0]) else $error("i2c bad code");
	a_mode_fixed: assert property (host_link_mode != DLM_LINK_NONE |=>
		$stable(host_link_mode)) else $error("mode moved");
	// stalled word stays put
	a_word_hold: assert property (word_valid && !word_ready |=>
		word_valid && $stable(word_data)) else $error("word moved");
	// one strobe per command beat
	a_cmd_pulse: assert property (cmd_lanes_valid |=>
		!cmd_lanes_valid [*6]) else $error("cmd strobe long");
endmodule : dlm_lane_mapper_sva
bind dlm_lane_mapper dlm_lane_mapper_sva dlm_lane_mapper_sva_inst (.*);
`default_nettype wire

// ### verif/dlm_lane_mapper_bench.sv
// bench: strap decode, lane mapping, buffer and sync outputs
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin \
	n_checks++; \
	if ((s) !== (e)) begin \
		err_total++; \
		$display("MISMATCH %s exp %0h got %0h", nm, e, s); \
	end \
end
module dlm_lane_mapper_bench;
	import dlm_pkg::*;
	logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic pready, pslverr, cmd_lanes_valid, word_valid, word_ready = '0;
	logic frame_sync_src = '0, touch_sync_src = '0;
	logic frame_sync_out, touch_sync_out;
	logic [3:0] port_a_lane_oe, port_b_lane_oe, cmd_lanes;
	dlm_port_pins_t port_a_pins, port_b_pins;
	dlm_link_mode_t host_link_mode;
	dlm_word_t word_data;
	dlm_straps_t st = '0;
	int err_total = 0, n_checks = 0, n_cmd = 0;
	dlm_lane_mapper dlm_lane_mapper_inst (.*, .lane_order_code_a(st.order_a),
		.lane_order_code_b(st.order_b), .lane_polarity_flip_a(st.flip_a),
		.lane_polarity_flip_b(st.flip_b), .port_order_select(st.port_order),
		.cmd_port_select(st.cmd_port), .host_link_select(st.host_link));
	dlm_host_model dlm_host_model_inst (.*);
	// count command strobes
	always @(posedge pclk) begin
		if (cmd_lanes_valid === 1'b1) begin
			n_cmd <= n_cmd + 1;
		end
	end
	// 50 MHz clock
	initial forever #10 pclk = ~pclk;
	// verdict and end of run
	task automatic conclude;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude
	// one apb transfer, waits for pready
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			err_total++;
			conclude();
		end
	endtask : apb
	// read and compare data and error flag
	task automatic rd(input logic [7:0] a, input logic [31:0] x,
		input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, '0, r, e);
		`CHK("prdata", x, r)
		`CHK("pslverr", xe, e)
	endtask : rd
	// logical lanes from pin pairs D0..D3
	function automatic logic [3:0] lmap(logic [1:0] c, logic [3:0] p);
		case (c)
			2'h0: return {p[0], p[1], p[2], p[3]};
			2'h1: return p;
			2'h2: return {p[3], p[0], p[1], p[2]};
			default: return {p[0], p[3], p[2], p[1]};
		endcase
	endfunction : lmap
	// reset with a strap set, wait past the latch
	task automatic rst(input dlm_straps_t s);
		@(posedge pclk);
		presetn <= 1'b0;
		st <= s;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (8) @(posedge pclk);
	endtask : rst
	// take one word with ready high
	task automatic get(input dlm_word_t x);
		int k = 0;
		word_ready <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (!(word_valid === 1'b1 && word_ready === 1'b1) && k < 40);
		if (!(word_valid === 1'b1 && word_ready === 1'b1)) begin
			err_total++;
			conclude();
		end
		`CHK("word", x, word_data)
	endtask : get
	// one strap set: decode, register view, one paired beat
	task automatic t_cfg(input logic [1:0] i);
		dlm_straps_t s;
		logic [1:0] m;
		logic [3:0] la, lb;
		int c;
		s = {i, i[0], i[1], ~i[0], ~i, i[0], i};
		m = (i == 2'h1) ? 2'h1 : (i == 2'h3) ? 2'h2 : 2'h0;
		la = lmap(i, 4'hb);
		lb = lmap(~i, 4'he);
		rst(s);
		`CHK("mode", dlm_link_mode_t'(m), host_link_mode)
		rd(DLM_STRAP_OFS, {20'h0, m, s}, 1'b0);
		`CHK("oe", 8'h0, {port_a_lane_oe, port_b_lane_oe})
		c = n_cmd;
		fork
			dlm_host_model_inst.beat(4'hb, 4'he, i[0], ~i[0]);
			get(i[0] ^ i[1] ? {lb, la} : {la, lb});
		join
		`CHK("cmd", i[0] ? lb : la, cmd_lanes)
		`CHK("cmd_valid", c + 1, n_cmd)
	endtask : t_cfg
	// fill both entries under stall, lose the third, drain, clear
	task automatic t_buf;
		logic [31:0] r;
		logic e;
		word_ready <= 1'b0;
		st <= '0; // straps move without a reset
		for (int k = 0; k < 3; k++)
			dlm_host_model_inst.beat(4'(k), 4'(k + 9), 1'b1, 1'b0);
		rd(DLM_STAT_OFS, 32'h5, 1'b0);
		get({lmap(2'h3, 4'h0), lmap(2'h0, 4'h9)});
		get({lmap(2'h3, 4'h1), lmap(2'h0, 4'ha)});
		rd(DLM_STAT_OFS, 32'h1, 1'b0);
		apb(1'b1, DLM_STAT_OFS, 32'h1, r, e);
		rd(DLM_STAT_OFS, 32'h0, 1'b0);
		rd(DLM_STRAP_OFS, 32'hbc7, 1'b0);
	endtask : t_buf
	// sync outputs high only when enabled, with both sources held high
	task automatic t_sync;
		logic [31:0] r;
		logic e;
		frame_sync_src <= 1'b1;
		touch_sync_src <= 1'b1;
		rd(DLM_CTRL_OFS, 32'h0, 1'b0);
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, DLM_CTRL_OFS, 32'(k), r, e);
			repeat (2) @(posedge pclk);
			`CHK("fsync", k[0], frame_sync_out)
			`CHK("tsync", k[1], touch_sync_out)
		end
		rd(8'h0c, 32'h0, 1'b1);
	endtask : t_sync
	// main sequence
	initial begin
		for (int i = 0; i < 4; i++)
			t_cfg(2'(i));
		t_buf();
		t_sync();
		conclude();
	end
endmodule : dlm_lane_mapper_bench
`default_nettype wire
